// >>> aic_top.sv
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module aic_top (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire aic_pkg::aic_bus_t bus,
  output logic [aic_pkg::DATA_W-1:0] rd_data,
  // Condition inputs
  input wire aic_pkg::aic_cond_t cond_in,
  // Sensor magnitudes
  input wire aic_pkg::aic_mags_t mag_in,
  // Retained settings store
  input wire logic [aic_pkg::CTRL_W-1:0] nv_ctrl,
  input wire aic_pkg::aic_mag_t nv_thresh,
  output logic save_stb,
  output logic [aic_pkg::CTRL_W-1:0] save_ctrl,
  output aic_pkg::aic_mag_t save_thresh,
  // Indicators
  output aic_pkg::aic_ind_t ind,
  // Detection signal outputs
  output aic_pkg::aic_mags_t mag_out,
  output aic_pkg::aic_mag_t mag_mux,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  aic_pkg::aic_cond_t cond_s;
  aic_pkg::aic_mode_t mode;
  aic_pkg::aic_mode_t next_mode;
  aic_pkg::aic_ind_t next_ind;
  logic [aic_pkg::CTRL_W-1:0] ctrl;
  aic_pkg::aic_mag_t thresh;
  logic load_pend;
  logic [aic_pkg::NZONE-1:0] hit_q;
  logic [aic_pkg::EV_W-1:0] ev_prev;
  logic [aic_pkg::EV_W-1:0] irq_stat;
  logic [aic_pkg::EV_W-1:0] irq_en;

  // ****************************************************************
  // Input capture
  // ****************************************************************
  aic_sync #(
    .W(aic_pkg::COND_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(cond_in),
    .q(cond_s)
  );

  aic_zone u_zone (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .mag_in(mag_in),
    .thresh(thresh),
    .mag_q(mag_out),
    .hit_q(hit_q)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire wr_ctrl = bus.wr && (bus.addr == aic_pkg::A_CTRL);
  wire wr_thresh = bus.wr && (bus.addr == aic_pkg::A_THRESH);
  wire wr_en = bus.wr && (bus.addr == aic_pkg::A_IRQ_EN);
  wire wr_clr = bus.wr && (bus.addr == aic_pkg::A_IRQ_CLR);

  wire run_en = ctrl[aic_pkg::C_RUN];
  wire mux_en = ctrl[aic_pkg::C_MUX];
  wire aud_viol_en = ctrl[aic_pkg::C_AUD_VIOL];
  wire aud_stat_en = ctrl[aic_pkg::C_AUD_STAT];
  wire [aic_pkg::SEL_W-1:0] sel = ctrl[aic_pkg::C_SEL_HI:aic_pkg::C_SEL_LO];

  // ****************************************************************
  // Readiness
  // ****************************************************************
  wire armed = (mode != aic_pkg::M_RESET);
  wire ready = (mode == aic_pkg::M_READY);
  wire metal_hit = |hit_q;
  // A zone that is alarming also holds the portal closed.
  wire conds_ok = cond_s.det_ready && !cond_s.pwr_bad &&
                  !cond_s.hlth_bad && run_en && !metal_hit;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      aic_pkg::M_RESET: begin
        if (cond_s.det_ready) begin
          next_mode = conds_ok ? aic_pkg::M_READY : aic_pkg::M_NOTREADY;
        end
      end
      aic_pkg::M_NOTREADY: begin
        if (conds_ok) begin
          next_mode = aic_pkg::M_READY;
        end
      end
      aic_pkg::M_READY: begin
        if (!conds_ok) begin
          next_mode = aic_pkg::M_NOTREADY;
        end
      end
      default: begin
        next_mode = aic_pkg::M_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= aic_pkg::M_RESET;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  // ****************************************************************
  // Alarm conditions
  // ****************************************************************
  // Nothing alarms before the detection path has first reported ready.
  wire metal_alm = armed && metal_hit;
  wire pwr_alm = armed && cond_s.pwr_bad;
  wire stat_alm = armed && cond_s.hlth_bad;
  wire viol_alm = armed && cond_s.passage && !ready;
  wire mute = cond_s.earphone;

  always_comb begin
    next_ind = aic_pkg::IND_RST;
    next_ind.aud_metal = metal_alm && !mute;
    next_ind.aud_power = pwr_alm && !mute;
    next_ind.aud_status = stat_alm && aud_stat_en && !mute;
    next_ind.aud_viol = viol_alm && aud_viol_en && !mute;
    next_ind.vis_metal = metal_alm;
    next_ind.vis_status = stat_alm;
    next_ind.vis_viol = viol_alm;
    next_ind.lamp_go = ready;
    next_ind.lamp_stop = !ready;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ind <= aic_pkg::IND_RST;
    end else if (ce) begin
      ind <= next_ind;
    end
  end

  // ****************************************************************
  // Multiplexed detection output
  // ****************************************************************
  wire aic_pkg::aic_mag_t sel_mag = mag_out[sel];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mag_mux <= '0;
    end else if (ce) begin
      mag_mux <= mux_en ? sel_mag : '0;
    end
  end

  // ****************************************************************
  // Settings
  // ****************************************************************
  // The retained store is read back on the first enabled edge after
  // reset, so a supply dip cannot fall back to default sensitivity.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= aic_pkg::CTRL_RST;
      thresh <= aic_pkg::THRESH_RST;
      load_pend <= 1'b1;
      save_stb <= 1'b0;
    end else if (ce) begin
      load_pend <= 1'b0;
      save_stb <= !load_pend && (wr_ctrl || wr_thresh);
      if (load_pend) begin
        ctrl <= nv_ctrl;
        thresh <= nv_thresh;
      end else begin
        if (wr_ctrl) begin
          ctrl <= bus.wdata[aic_pkg::CTRL_W-1:0];
        end
        if (wr_thresh) begin
          thresh <= bus.wdata[aic_pkg::MAG_W-1:0];
        end
      end
    end
  end

  assign save_ctrl = ctrl;
  assign save_thresh = thresh;

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  wire [aic_pkg::EV_W-1:0] ev_now = {viol_alm, stat_alm, pwr_alm, metal_alm};
  wire [aic_pkg::EV_W-1:0] ev_rise = ev_now & ~ev_prev;
  wire [aic_pkg::EV_W-1:0] clr_mask =
    wr_clr ? bus.wdata[aic_pkg::EV_W-1:0] : aic_pkg::EV_RST;
  // A new event in the clearing cycle survives the clear.
  wire [aic_pkg::EV_W-1:0] next_stat = (irq_stat & ~clr_mask) | ev_rise;
  wire [aic_pkg::EV_W-1:0] next_en =
    wr_en ? bus.wdata[aic_pkg::EV_W-1:0] : irq_en;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev <= aic_pkg::EV_RST;
      irq_stat <= aic_pkg::EV_RST;
      irq_en <= aic_pkg::EV_RST;
      irq <= 1'b0;
    end else if (ce) begin
      ev_prev <= ev_now;
      irq_stat <= next_stat;
      irq_en <= next_en;
      irq <= |(next_stat & next_en);
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  wire [aic_pkg::STATE_W-1:0] state_word = {ready, armed,
    cond_s.earphone, viol_alm, stat_alm, pwr_alm, metal_alm};

  wire [aic_pkg::DATA_W-1:0] rd_word =
    (bus.addr == aic_pkg::A_CTRL) ?
      {{(aic_pkg::DATA_W-aic_pkg::CTRL_W){1'b0}}, ctrl} :
    (bus.addr == aic_pkg::A_THRESH) ?
      {{(aic_pkg::DATA_W-aic_pkg::MAG_W){1'b0}}, thresh} :
    (bus.addr == aic_pkg::A_STATE) ?
      {{(aic_pkg::DATA_W-aic_pkg::STATE_W){1'b0}}, state_word} :
    (bus.addr == aic_pkg::A_IRQ_STAT) ?
      {{(aic_pkg::DATA_W-aic_pkg::EV_W){1'b0}}, irq_stat} :
    (bus.addr == aic_pkg::A_IRQ_EN) ?
      {{(aic_pkg::DATA_W-aic_pkg::EV_W){1'b0}}, irq_en} :
    (bus.addr == aic_pkg::A_MAG) ?
      {{(aic_pkg::DATA_W-aic_pkg::MAG_W){1'b0}}, sel_mag} :
      '0;

  // Read data is zero outside the cycle after a read strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= bus.rd ? rd_word : '0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  wire any_aud = ind.aud_metal || ind.aud_power ||
                 ind.aud_status || ind.aud_viol;

  mute_audio_a: assert property (
    (ce && cond_s.earphone) |=> !any_aud)
    else $error("audible output active with earphone in");

  metal_alarm_a: assert property (
    (ce && armed && metal_hit && !cond_s.earphone) |=>
      (ind.aud_metal && ind.vis_metal))
    else $error("metal hit did not raise both alarms");

  metal_dark_a: assert property (
    (ce && !metal_hit) |=> !ind.vis_metal)
    else $error("metal lamp lit without a zone hit");

  power_alarm_a: assert property (
    (ce && armed && cond_s.pwr_bad && !cond_s.earphone) |=> ind.aud_power)
    else $error("power fault did not sound");

  status_lamp_a: assert property (
    (ce && armed) |=> (ind.vis_status == $past(cond_s.hlth_bad)))
    else $error("status lamp does not follow health");

  viol_lamp_a: assert property (
    (ce && ready) |=> !ind.vis_viol)
    else $error("violation lamp lit while ready");

  go_ready_a: assert property (
    (ce && ready) |=> ind.lamp_go)
    else $error("green lamp off while ready");

  stop_go_a: assert property (
    ind.lamp_stop == !ind.lamp_go)
    else $error("red and green lamps not exclusive");

  reset_red_a: assert property (
    (ce && !armed) |=> (ind.lamp_stop && !ind.vis_metal && !any_aud))
    else $error("alarm or green lamp before first ready");

  mux_select_a: assert property (
    (ce && mux_en) |=> (mag_mux == $past(sel_mag)))
    else $error("multiplexed output not the selected zone");

  silent_idle_a: assert property (
    (ce && !(metal_alm || pwr_alm || stat_alm || viol_alm)) |=> !any_aud)
    else $error("sound while not alarming");

  viol_alarm_a: assert property (
    (ce && armed && cond_s.passage && !ready) |=> ind.vis_viol)
    else $error("passage while not ready left violation lamp dark");

  mag_export_a: assert property (
    ce |=> (mag_out == $past(mag_in)))
    else $error("exported magnitude is not the judged sample");

  nv_load_a: assert property (
    (ce && load_pend) |=>
      ((ctrl == $past(nv_ctrl)) && (thresh == $past(nv_thresh))))
    else $error("retained settings not restored after reset");

  sync_delay_a: assert property (
    (ce ##1 ce) |=> (cond_s == $past(cond_in, 2)))
    else $error("condition input not two stages behind");

  metal_cov_c: cover property (ce && ind.aud_metal);
  viol_cov_c: cover property (ce && ind.vis_viol);
  irq_cov_c: cover property (irq && wr_clr);
  ready_cov_c: cover property (!ready ##1 ready);

endmodule

// >>> aic_pkg.sv
package aic_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NZONE = 4;
  localparam int MAG_W = 12;
  localparam int SEL_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_THRESH = 8'h04;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h08;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] A_IRQ_EN = 8'h10;
  localparam logic [ADDR_W-1:0] A_IRQ_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] A_MAG = 8'h18;

  // ****************************************************************
  // Control fields and reset values
  // ****************************************************************
  localparam int CTRL_W = 6;
  localparam int C_RUN = 0;
  localparam int C_MUX = 1;
  localparam int C_SEL_LO = 2;
  localparam int C_SEL_HI = 3;
  localparam int C_AUD_VIOL = 4;
  localparam int C_AUD_STAT = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
  localparam logic [MAG_W-1:0] THRESH_RST = 12'h800;

  // ****************************************************************
  // Events and state word
  // ****************************************************************
  localparam int EV_W = 4;
  localparam int EV_METAL = 0;
  localparam int EV_POWER = 1;
  localparam int EV_STAT = 2;
  localparam int EV_VIOL = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam int STATE_W = 7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } aic_bus_t;

  typedef struct packed {
    logic det_ready;
    logic hlth_bad;
    logic pwr_bad;
    logic passage;
    logic earphone;
  } aic_cond_t;

  localparam int COND_W = 5;

  typedef struct packed {
    logic aud_metal;
    logic aud_power;
    logic aud_status;
    logic aud_viol;
    logic vis_metal;
    logic vis_status;
    logic vis_viol;
    logic lamp_go;
    logic lamp_stop;
  } aic_ind_t;

  localparam aic_ind_t IND_RST = 9'h001;

  typedef logic [MAG_W-1:0] aic_mag_t;
  typedef aic_mag_t [NZONE-1:0] aic_mags_t;

  typedef enum logic [1:0] {
    M_RESET = 2'b00,
    M_NOTREADY = 2'b01,
    M_READY = 2'b11
  } aic_mode_t;

endpackage

// >>> aic_sync.sv
`timescale 1ns/1ps
module aic_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ****************************************************************
  // Two-stage synchroniser
  // ****************************************************************
  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// >>> aic_zone.sv
`timescale 1ns/1ps
module aic_zone (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Sensor side
  input wire aic_pkg::aic_mags_t mag_in,
  input wire aic_pkg::aic_mag_t thresh,
  // Registered results
  output aic_pkg::aic_mags_t mag_q,
  output logic [aic_pkg::NZONE-1:0] hit_q
);

  // ****************************************************************
  // Per-zone capture and decision
  // ****************************************************************
  // Magnitude and decision are taken from one sample in one edge, so
  // the exported value is exactly the one the alarm is judged on.
  genvar z;
  generate
    for (z = 0; z < aic_pkg::NZONE; z++) begin : g_zone
      wire hit_now = (mag_in[z] >= thresh);
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          mag_q[z] <= '0;
          hit_q[z] <= 1'b0;
        end else if (ce) begin
          mag_q[z] <= mag_in[z];
          hit_q[z] <= hit_now;
        end
      end
    end
  endgenerate

endmodule

// >>> aic_nv_model.sv
`timescale 1ns/1ps
module aic_nv_model (
  // Clock
  input wire logic core_clk,
  // Save side
  input wire logic save_stb,
  input wire logic [aic_pkg::CTRL_W-1:0] save_ctrl,
  input wire aic_pkg::aic_mag_t save_thresh,
  // Restore side
  output logic [aic_pkg::CTRL_W-1:0] nv_ctrl,
  output aic_pkg::aic_mag_t nv_thresh
);
  // No reset input: the store has to outlive every reset of the core.
  initial begin
    nv_ctrl = aic_pkg::CTRL_RST;
    nv_thresh = aic_pkg::THRESH_RST;
  end

  always @(posedge core_clk) begin
    if (save_stb) begin
      nv_ctrl <= save_ctrl;
      nv_thresh <= save_thresh;
    end
  end
endmodule

// >>> alarm_indicator_controller_tb_top.sv
`timescale 1ns/1ps
module alarm_indicator_controller_tb_top;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [4:0] cond;
    logic [1:0] zone;
    logic [11:0] mag;
    logic [8:0] ind;
  } aic_row_t;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  aic_pkg::aic_bus_t bus = '0;
  aic_pkg::aic_cond_t cond_in = '0;
  aic_pkg::aic_mags_t mag_in = '0;
  logic [aic_pkg::DATA_W-1:0] rd_data;
  logic [aic_pkg::CTRL_W-1:0] nv_ctrl;
  logic [aic_pkg::CTRL_W-1:0] save_ctrl;
  aic_pkg::aic_mag_t nv_thresh;
  aic_pkg::aic_mag_t save_thresh;
  aic_pkg::aic_mag_t mag_mux;
  aic_pkg::aic_mags_t mag_out;
  aic_pkg::aic_ind_t ind;
  logic save_stb;
  logic irq;
  int fail_count = 0;
  int comparisons = 0;
  aic_row_t rows [12];

  always #25 core_clk = ~core_clk;

  aic_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rd_data(rd_data), .cond_in(cond_in), .mag_in(mag_in),
    .nv_ctrl(nv_ctrl), .nv_thresh(nv_thresh), .save_stb(save_stb),
    .save_ctrl(save_ctrl), .save_thresh(save_thresh), .ind(ind),
    .mag_out(mag_out), .mag_mux(mag_mux), .irq(irq));

  aic_nv_model nv_u (.core_clk(core_clk), .save_stb(save_stb),
    .save_ctrl(save_ctrl), .save_thresh(save_thresh),
    .nv_ctrl(nv_ctrl), .nv_thresh(nv_thresh));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask

  // Two sync stages, one output stage and one mode stage, plus margin.
  task automatic apply(input logic [4:0] c, input aic_pkg::aic_mags_t m);
    @(posedge core_clk);
    cond_in <= c;
    mag_in <= m;
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    aic_pkg::aic_mags_t m;
    aic_row_t r;
    rows[0] = '{6'h01, 5'h10, 2'd0, 12'h000, 9'h002};
    rows[1] = '{6'h01, 5'h14, 2'd0, 12'h000, 9'h081};
    rows[2] = '{6'h01, 5'h18, 2'd0, 12'h000, 9'h009};
    rows[3] = '{6'h21, 5'h18, 2'd0, 12'h000, 9'h049};
    rows[4] = '{6'h00, 5'h12, 2'd0, 12'h000, 9'h005};
    rows[5] = '{6'h10, 5'h12, 2'd0, 12'h000, 9'h025};
    rows[6] = '{6'h01, 5'h12, 2'd1, 12'h123, 9'h002};
    rows[7] = '{6'h0b, 5'h10, 2'd2, 12'h800, 9'h111};
    rows[8] = '{6'h0f, 5'h10, 2'd3, 12'h7ff, 9'h002};
    rows[9] = '{6'h0b, 5'h11, 2'd2, 12'h800, 9'h011};
    rows[10] = '{6'h01, 5'h15, 2'd0, 12'h000, 9'h001};
    rows[11] = '{6'h00, 5'h10, 2'd0, 12'h000, 9'h001};
    repeat (3) @(posedge core_clk);
    #1;
    check(ind, 9'h001);
    check(irq, 1'b0);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdchk(aic_pkg::A_CTRL, 32'h1);
    rdchk(aic_pkg::A_THRESH, 32'h800);
    rdchk(8'hfc, 32'h0);
    apply(5'h02, '0);
    check(ind, 9'h001);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      wr(aic_pkg::A_CTRL, {26'h0, r.ctrl});
      m = '0;
      m[r.zone] = r.mag;
      apply(r.cond, m);
      check(ind, r.ind);
      check(mag_out[r.zone], r.mag);
      check(mag_mux, r.ctrl[1] ? r.mag : 12'h000);
      rdchk(aic_pkg::A_MAG, {20'h0, m[r.ctrl[3:2]]});
      $display("row %0d done", i);
    end
    rdchk(aic_pkg::A_STATE, 32'h20);
    // Events are sticky, so the alarming rows above left a trail to clear.
    wr(aic_pkg::A_CTRL, 32'h1);
    wr(aic_pkg::A_IRQ_CLR, 32'hf);
    wr(aic_pkg::A_IRQ_EN, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    check(irq, 1'b0);
    rdchk(aic_pkg::A_IRQ_STAT, 32'h0);
    rdchk(aic_pkg::A_IRQ_EN, 32'h1);
    apply(5'h14, '0);
    apply(5'h10, '0);
    check(irq, 1'b0);
    rdchk(aic_pkg::A_IRQ_STAT, 32'h2);
    m = '0;
    m[1] = 12'hfff;
    apply(5'h10, m);
    check(irq, 1'b1);
    rdchk(aic_pkg::A_IRQ_STAT, 32'h3);
    rdchk(aic_pkg::A_STATE, 32'h21);
    apply(5'h10, '0);
    wr(aic_pkg::A_IRQ_CLR, 32'h1);
    wr(aic_pkg::A_IRQ_STAT, 32'h0);
    repeat (2) @(posedge core_clk);
    #1;
    check(irq, 1'b0);
    rdchk(aic_pkg::A_IRQ_STAT, 32'h2);
    $display("interrupt test done");
    // A low enable must freeze every stage, the synchroniser included.
    @(posedge core_clk);
    ce <= 1'b0;
    apply(5'h14, '0);
    check(ind, 9'h002);
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    check(ind, 9'h081);
    $display("enable test done");
    wr(aic_pkg::A_THRESH, 32'h7f0);
    #1;
    check(save_stb, 1'b1);
    check(save_thresh, 12'h7f0);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check(ind, 9'h001);
    check(rd_data, 32'h0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rdchk(aic_pkg::A_THRESH, 32'h7f0);
    $display("retention test done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    $display("[FAIL] t=%0t run limit reached", $time);
    fail_count++;
    end_of_test();
  end
endmodule
